// [verilog/gte_defines.svh]
// Register indices, field positions, reset values and sizes of the gyro threshold event block.
`ifndef GTE_DEFINES_SVH
`define GTE_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define GTE_IDX_CFG       6'h30
`define GTE_IDX_PTHR      6'h31
`define GTE_IDX_RTHR      6'h33
`define GTE_IDX_YTHR      6'h35
`define GTE_IDX_DURATION  6'h37
`define GTE_IDX_STATUS    6'h38
`define GTE_IDX_MASK      6'h39
`define GTE_IDX_SOURCE    6'h3a

// ****************************************************************
// Field layout
// ****************************************************************
`define GTE_CFG_W         9
`define GTE_THR_W         15
`define GTE_CNT_W         7
`define GTE_STS_W         2
`define GTE_DUR_WAIT_BIT  7
`define GTE_STS_RISE      0
`define GTE_STS_FALL      1

// ****************************************************************
// Reset values and the counter step
// ****************************************************************
`define GTE_CFG_RST       9'h000
`define GTE_THR_RST       15'h0000
`define GTE_CNT_RST       7'h00
`define GTE_STS_RST       2'h0
`define GTE_CNT_ONE       8'h01

`endif

// [verilog/gte_pkg.sv]
// Types shared by the gyro threshold event block.
package gte_pkg;

  // One gyroscope output sample; valid marks a new sample at the output data rate.
  typedef struct packed {
    logic        valid;
    logic [15:0] pitch;
    logic [15:0] roll;
    logic [15:0] yaw;
  } gte_sample_t;

  // Configuration word, bit 8 down to bit 0 as it sits in the register.
  typedef struct packed {
    logic       counter_decrement_select;
    logic       axis_event_combine;
    logic       request_latch_enable;
    logic [5:0] axis_en;
  } gte_cfg_t;

  typedef enum logic [0:0] {
    GTE_IDLE   = 1'b0,
    GTE_ACTIVE = 1'b1
  } gte_state_t;

endpackage

// [verilog/gte_top.sv]
// Gyro threshold and duration event generator with an Avalon-MM register slave.
`timescale 1ns/10ps
`include "gte_defines.svh"

module gte_top (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire gte_pkg::gte_sample_t sample_in,
  output logic                      gyro_int,
  output logic                      irq
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic hit(input logic [5:0] idx, input logic [5:0] target);
    hit = (idx == target);
  endfunction

  // Byte-lane merge for the two low lanes of a register word.
  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [`GTE_CFG_W-1:0] cfg_r;
  logic [`GTE_THR_W-1:0] pthr_r;
  logic [`GTE_THR_W-1:0] rthr_r;
  logic [`GTE_THR_W-1:0] ythr_r;
  logic [`GTE_CNT_W-1:0] dur_r;
  logic                  wait_r;
  logic [`GTE_STS_W-1:0] sts_r;
  logic [`GTE_STS_W-1:0] msk_r;
  logic [`GTE_CNT_W-1:0] cnt_r;
  logic [`GTE_CNT_W-1:0] cnt_nxt;
  logic                  latch_r;
  logic                  gyro_int_r;
  logic                  irq_r;
  logic                  waitreq_r;
  logic [31:0]           rdata_r;
  gte_pkg::gte_state_t   state_r;
  gte_pkg::gte_state_t   state_nxt;
  gte_pkg::gte_cfg_t     cfg;

  assign cfg = gte_pkg::gte_cfg_t'(cfg_r);

  // ****************************************************************
  // Avalon-MM slave decode
  // ****************************************************************
  // Every access waits exactly one cycle; the answer is registered so that
  // read data and waitrequest both come straight from flip-flops.
  wire [5:0]  idx         = avs_address[7:2];
  wire        bus_req     = avs_read | avs_write;
  wire        wr_go       = avs_write & ~waitreq_r;
  wire        rd_go       = avs_read & ~waitreq_r;
  wire        waitreq_nxt = ~(bus_req & waitreq_r);
  wire [15:0] wd16        = avs_writedata[15:0];
  wire [1:0]  be2         = avs_byteenable[1:0];

  wire wr_cfg  = wr_go & hit(idx, `GTE_IDX_CFG);
  wire wr_pthr = wr_go & hit(idx, `GTE_IDX_PTHR);
  wire wr_rthr = wr_go & hit(idx, `GTE_IDX_RTHR);
  wire wr_ythr = wr_go & hit(idx, `GTE_IDX_YTHR);
  wire wr_dur  = wr_go & hit(idx, `GTE_IDX_DURATION);
  wire wr_sts  = wr_go & hit(idx, `GTE_IDX_STATUS);
  wire wr_msk  = wr_go & hit(idx, `GTE_IDX_MASK);
  wire rd_src  = rd_go & hit(idx, `GTE_IDX_SOURCE);

  wire [15:0] cfg_m  = be_merge({7'h00, cfg_r}, wd16, be2);
  wire [15:0] pthr_m = be_merge({1'b0, pthr_r}, wd16, be2);
  wire [15:0] rthr_m = be_merge({1'b0, rthr_r}, wd16, be2);
  wire [15:0] ythr_m = be_merge({1'b0, ythr_r}, wd16, be2);
  wire [15:0] dur_m  = be_merge({8'h00, wait_r, dur_r}, wd16, be2);

  // Bit 15 of each threshold is not stored, so it always reads back as zero.
  wire [31:0] rd_mux =
    hit(idx, `GTE_IDX_CFG)      ? {23'h000000, cfg_r}               :
    hit(idx, `GTE_IDX_PTHR)     ? {17'h00000, pthr_r}               :
    hit(idx, `GTE_IDX_RTHR)     ? {17'h00000, rthr_r}               :
    hit(idx, `GTE_IDX_YTHR)     ? {17'h00000, ythr_r}               :
    hit(idx, `GTE_IDX_DURATION) ? {24'h000000, wait_r, dur_r}       :
    hit(idx, `GTE_IDX_STATUS)   ? {30'h00000000, sts_r}             :
    hit(idx, `GTE_IDX_MASK)     ? {30'h00000000, msk_r}             :
    hit(idx, `GTE_IDX_SOURCE)   ? {29'h00000000, state_r, latch_r, gyro_int_r} :
                                  32'h00000000;

  // ****************************************************************
  // Axis comparators
  // ****************************************************************
  wire [15:0] smp [3];
  wire [15:0] thr [3];
  wire [5:0]  ev;

  assign smp[0] = sample_in.pitch;
  assign smp[1] = sample_in.roll;
  assign smp[2] = sample_in.yaw;
  assign thr[0] = {pthr_r[`GTE_THR_W-1], pthr_r};
  assign thr[1] = {rthr_r[`GTE_THR_W-1], rthr_r};
  assign thr[2] = {ythr_r[`GTE_THR_W-1], ythr_r};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      // Low event in the even bit, high event in the odd bit of each axis pair.
      assign ev[2*gi]   = $signed(smp[gi]) < $signed(thr[gi]);
      assign ev[2*gi+1] = $signed(smp[gi]) > $signed(thr[gi]);
    end
  endgenerate

  wire [5:0] en_ev   = ev & cfg.axis_en;
  wire       any_en  = |cfg.axis_en;
  wire       and_ok  = any_en & (&(ev | ~cfg.axis_en));
  wire       cond    = cfg.axis_event_combine ? and_ok : |en_ev;

  // ****************************************************************
  // Duration counter and event state
  // ****************************************************************
  wire [7:0]             cnt_inc8 = {1'b0, cnt_r} + `GTE_CNT_ONE;
  wire                   reached  = cnt_inc8 >= {1'b0, dur_r};
  wire [`GTE_CNT_W-1:0]  cnt_inc  = cnt_inc8[`GTE_CNT_W-1:0];
  wire [`GTE_CNT_W-1:0]  cnt_dec  = (cnt_r == `GTE_CNT_RST) ? `GTE_CNT_RST :
                                    cnt_r - 7'h01;
  wire [`GTE_CNT_W-1:0]  cnt_back = cfg.counter_decrement_select ? cnt_dec :
                                    `GTE_CNT_RST;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (sample_in.valid) begin
      case (state_r)
        gte_pkg::GTE_IDLE: begin
          if (cond && reached) begin
            state_nxt = gte_pkg::GTE_ACTIVE;
            cnt_nxt = `GTE_CNT_RST;
          end else if (cond) begin
            cnt_nxt = cnt_inc;
          end else begin
            cnt_nxt = cnt_back;
          end
        end
        gte_pkg::GTE_ACTIVE: begin
          if (cond) begin
            cnt_nxt = cnt_back;
          end else if (!wait_r || reached) begin
            state_nxt = gte_pkg::GTE_IDLE;
            cnt_nxt = `GTE_CNT_RST;
          end else begin
            cnt_nxt = cnt_inc;
          end
        end
        default: begin
          state_nxt = gte_pkg::GTE_IDLE;
          cnt_nxt = `GTE_CNT_RST;
        end
      endcase
    end
  end

  // A latched request holds until software reads the source register; an entry
  // in the same cycle as that read wins, so no event is lost.
  wire enter     = (state_r == gte_pkg::GTE_IDLE) & (state_nxt == gte_pkg::GTE_ACTIVE);
  wire latch_nxt = cfg.request_latch_enable & (enter | (latch_r & ~rd_src));
  wire int_nxt   = (state_nxt == gte_pkg::GTE_ACTIVE) | latch_nxt;

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  wire [`GTE_STS_W-1:0] sts_set;
  wire [`GTE_STS_W-1:0] sts_clr = wr_sts ? avs_writedata[`GTE_STS_W-1:0] : `GTE_STS_RST;
  wire [`GTE_STS_W-1:0] sts_nxt;

  assign sts_set[`GTE_STS_RISE] = int_nxt & ~gyro_int_r;
  assign sts_set[`GTE_STS_FALL] = ~int_nxt & gyro_int_r;
  assign sts_nxt = sts_set | (sts_r & ~sts_clr);

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_r  <= `GTE_CFG_RST;
      pthr_r <= `GTE_THR_RST;
      rthr_r <= `GTE_THR_RST;
      ythr_r <= `GTE_THR_RST;
      dur_r  <= `GTE_CNT_RST;
      wait_r <= 1'b0;
      msk_r  <= `GTE_STS_RST;
    end else begin
      if (wr_cfg)  cfg_r  <= cfg_m[`GTE_CFG_W-1:0];
      if (wr_pthr) pthr_r <= pthr_m[`GTE_THR_W-1:0];
      if (wr_rthr) rthr_r <= rthr_m[`GTE_THR_W-1:0];
      if (wr_ythr) ythr_r <= ythr_m[`GTE_THR_W-1:0];
      if (wr_dur)  dur_r  <= dur_m[`GTE_CNT_W-1:0];
      if (wr_dur)  wait_r <= dur_m[`GTE_DUR_WAIT_BIT];
      if (wr_msk)  msk_r  <= avs_writedata[`GTE_STS_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r    <= gte_pkg::GTE_IDLE;
      cnt_r      <= `GTE_CNT_RST;
      latch_r    <= 1'b0;
      gyro_int_r <= 1'b0;
      sts_r      <= `GTE_STS_RST;
      irq_r      <= 1'b0;
      waitreq_r  <= 1'b1;
      rdata_r    <= 32'h00000000;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      latch_r    <= latch_nxt;
      gyro_int_r <= int_nxt;
      sts_r      <= sts_nxt;
      irq_r      <= |(sts_r & msk_r);
      waitreq_r  <= waitreq_nxt;
      rdata_r    <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitreq_r;
  assign gyro_int        = gyro_int_r;
  assign irq             = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wire roll_hi_only = (cfg.axis_en == 6'h08) & ~cfg.axis_event_combine;
  wire idle         = (state_r == gte_pkg::GTE_IDLE);
  wire active       = (state_r == gte_pkg::GTE_ACTIVE);

  property p_bus_ack;
    bus_req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer not after one cycle");

  property p_reserved_zero;
    rd_go && (hit(idx, `GTE_IDX_RTHR) || hit(idx, `GTE_IDX_YTHR)) |-> !avs_readdata[15];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("threshold bit 15 read as one");

  property p_roll_write;
    wr_rthr && (be2 == 2'h3) |=> rthr_r == $past(avs_writedata[14:0]);
  endproperty
  a_roll_write: assert property (p_roll_write)
    else $error("roll threshold not stored");

  property p_yaw_write;
    wr_ythr && (be2 == 2'h3) |=> ythr_r == $past(avs_writedata[14:0]);
  endproperty
  a_yaw_write: assert property (p_yaw_write)
    else $error("yaw threshold not stored");

  property p_first_hit;
    idle && roll_hi_only && (dur_r == 7'h00) && sample_in.valid &&
      ($signed(sample_in.roll) > $signed(thr[1])) |=> gyro_int;
  endproperty
  a_first_hit: assert property (p_first_hit)
    else $error("signed compare with zero duration did not raise");

  property p_count_up;
    idle && sample_in.valid && cond && !reached && !latch_r |=>
      !gyro_int && (cnt_r == $past(cnt_r) + 7'h01);
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("duration counter did not advance");

  property p_no_wait_drop;
    active && !wait_r && sample_in.valid && !cond && !cfg.request_latch_enable |=> !gyro_int;
  endproperty
  a_no_wait_drop: assert property (p_no_wait_drop)
    else $error("interrupt did not drop at once");

  property p_wait_hold;
    active && wait_r && (dur_r == 7'h03) && (cnt_r == 7'h00) && sample_in.valid && !cond
      |=> gyro_int && (cnt_r == 7'h01);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("interrupt not held while waiting");

  property p_wait_reset;
    $fell(rst) |-> !wait_r && (dur_r == 7'h00);
  endproperty
  a_wait_reset: assert property (p_wait_reset)
    else $error("duration register not cleared by reset");

  property p_disabled;
    idle && (cfg.axis_en == 6'h00) && !latch_r && sample_in.valid |=> !gyro_int;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("interrupt with every axis disabled");

  property p_and_partial;
    idle && cfg.axis_event_combine && (en_ev != cfg.axis_en) && !latch_r && sample_in.valid
      |=> !gyro_int;
  endproperty
  a_and_partial: assert property (p_and_partial)
    else $error("AND combine raised on partial event");

  property p_latch_hold;
    latch_r && !rd_src && cfg.request_latch_enable |=> gyro_int;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched request dropped");

  property p_reset_mode;
    idle && sample_in.valid && !cond && !cfg.counter_decrement_select |=> cnt_r == 7'h00;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("counter not reset when condition broke");

  property p_irq;
    |(sts_r & msk_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked status did not raise irq");

  c_enter: cover property (idle ##1 active);
  c_wait_hold: cover property (active && wait_r && !cond && sample_in.valid ##1 active);
  c_latched: cover property (latch_r && idle);
  c_src_read: cover property (rd_src && latch_r);

endmodule

// [dv/gte_gyro_src.sv]
// Behavioural gyroscope sample source that feeds the event block one sample per request.
`timescale 1ns/10ps

module gte_gyro_src (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 send,
  input  wire logic [15:0]          pitch,
  input  wire logic [15:0]          roll,
  input  wire logic [15:0]          yaw,
  output gte_pkg::gte_sample_t      sample_out
);

  // Between samples the axis lines flip every cycle, so a block that reads them
  // without valid sees changing values rather than a lucky repeat of the last sample.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_out <= '0;
    end else if (send) begin
      sample_out <= {1'h1, pitch, roll, yaw};
    end else begin
      sample_out <= {1'h0, ~sample_out.pitch, ~sample_out.roll, ~sample_out.yaw};
    end
  end

endmodule

// [dv/gte_top_bench.sv]
// Self-checking testbench of the gyro threshold event block.
`timescale 1ns/10ps
`include "gte_defines.svh"

module gte_top_bench;
  logic                 mclk;
  logic                 rst;
  logic [7:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [3:0]           avs_byteenable;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  gte_pkg::gte_sample_t sample_in;
  logic                 gyro_int;
  logic                 irq;
  logic                 send;
  logic [15:0]          s_p;
  logic [15:0]          s_r;
  logic [15:0]          s_y;
  logic                 v_d;
  logic [31:0]          rd_q[$];
  logic                 int_q[$];
  logic                 irq_q[$];
  logic                 irq_look;
  int                   mismatches;
  int                   check_count;

  gte_top gte_top_inst (
    .mclk            (mclk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .sample_in       (sample_in),
    .gyro_int        (gyro_int),
    .irq             (irq)
  );

  gte_gyro_src gte_gyro_src_inst (
    .mclk       (mclk),
    .rst        (rst),
    .send       (send),
    .pitch      (s_p),
    .roll       (s_r),
    .yaw        (s_y),
    .sample_out (sample_in)
  );

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic compare_rd(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t read data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_int(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t event request got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic compare_irq(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t irq level got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_address   <= {idx, 2'h0};
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
    if (n >= 20) begin
      mismatches++;
      $display("BAD %0t bus access never completed", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'h1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'h0, idx, 32'h0);
  endtask

  task automatic smp(input logic [15:0] r, input logic [15:0] y, input logic e);
    int_q.push_back(e);
    @(posedge mclk);
    send <= 1'h1;
    s_p  <= 16'($urandom);
    s_r  <= r;
    s_y  <= y;
    @(posedge mclk);
    send <= 1'h0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
  endtask

  // Both thresholds sit at +100 so that a sample of 100 is neither high nor low.
  task automatic setup(input logic [31:0] cfg, input logic [31:0] dur);
    do_reset();
    wr(`GTE_IDX_RTHR, 32'h0064);
    wr(`GTE_IDX_YTHR, 32'h0064);
    wr(`GTE_IDX_CFG, cfg);
    wr(`GTE_IDX_DURATION, dur);
  endtask

  // The monitor looks at irq on the second edge, after the one-cycle status lag.
  task automatic irq_is(input logic e);
    irq_q.push_back(e);
    @(posedge mclk);
    irq_look <= 1'h1;
    @(posedge mclk);
    irq_look <= 1'h0;
  endtask

  function automatic logic [15:0] above();
    return 16'h0065 + 16'($urandom_range(300, 0));
  endfunction

  // ****************************************************************
  // Monitors
  // ****************************************************************
  always @(posedge mclk) begin
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0 && rd_q.size() > 0)
      compare_rd(avs_readdata, rd_q.pop_front());
    if (v_d === 1'h1 && int_q.size() > 0)
      compare_int(gyro_int, int_q.pop_front());
    if (irq_look === 1'h1 && irq_q.size() > 0)
      compare_irq(irq, irq_q.pop_front());
    v_d = sample_in.valid;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [15:0] h;
    rst = 1'h1;
    avs_address = 8'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    send = 1'h0;
    s_p = 16'h0;
    s_r = 16'h0;
    s_y = 16'h0;
    v_d = 1'h0;
    irq_look = 1'h0;
    mismatches = 0;
    check_count = 0;
    void'($urandom(32'hd24039da));
    do_reset();
    rd(`GTE_IDX_CFG, 32'h0);
    rd(`GTE_IDX_RTHR, 32'h0);
    rd(`GTE_IDX_YTHR, 32'h0);
    rd(`GTE_IDX_DURATION, 32'h0);
    rd(`GTE_IDX_PTHR, 32'h0);
    wr(6'h32, 32'hffff);
    rd(6'h32, 32'h0);
    wr(`GTE_IDX_RTHR, 32'h7fff);
    rd(`GTE_IDX_RTHR, 32'h7fff);
    wr(`GTE_IDX_YTHR, 32'h0123);
    rd(`GTE_IDX_YTHR, 32'h0123);
    wr(`GTE_IDX_DURATION, 32'hff);
    rd(`GTE_IDX_DURATION, 32'hff);
    // OR of roll high and yaw high, two samples needed, immediate release.
    setup(32'h28, 32'h02);
    h = above();
    smp(h, 16'h0, 1'h0);
    smp(h, 16'h0, 1'h1);
    smp(16'h0064, 16'h0, 1'h0);
    smp(16'h0, h, 1'h0);
    smp(16'h0, h, 1'h1);
    smp(16'h0, 16'h0, 1'h0);
    rd(`GTE_IDX_STATUS, 32'h3);
    irq_is(1'h0);
    wr(`GTE_IDX_MASK, 32'h1);
    irq_is(1'h1);
    wr(`GTE_IDX_STATUS, 32'h1);
    irq_is(1'h0);
    rd(`GTE_IDX_STATUS, 32'h2);
    // Negative yaw threshold of -256 with the low event and zero duration.
    setup(32'h10, 32'h00);
    wr(`GTE_IDX_YTHR, 32'h7f00);
    smp(16'h0, 16'hfeff - 16'($urandom_range(500, 0)), 1'h1);
    smp(16'h0, 16'hff00, 1'h0);
    smp(16'h0, 16'h0064, 1'h0);
    // Wait set with a duration of three holds the request for two quiet samples and drops it on the third.
    setup(32'h08, 32'h83);
    smp(above(), 16'h0, 1'h0);
    smp(above(), 16'h0, 1'h0);
    smp(above(), 16'h0, 1'h1);
    smp(16'h0, 16'h0, 1'h1);
    smp(16'h0, 16'h0, 1'h1);
    smp(16'h0, 16'h0, 1'h0);
    // A broken run clears the count in reset mode and costs one step in decrement mode.
    for (int m = 0; m < 2; m++) begin
      setup(32'h08 | (32'(m) << 8), 32'h03);
      smp(above(), 16'h0, 1'h0);
      smp(above(), 16'h0, 1'h0);
      smp(16'h0, 16'h0, 1'h0);
      smp(above(), 16'h0, 1'h0);
      smp(above(), 16'h0, 1'(m));
    end
    // AND of roll high and yaw high.
    setup(32'ha8, 32'h00);
    smp(above(), 16'h0, 1'h0);
    smp(16'h0, above(), 1'h0);
    smp(above(), above(), 1'h1);
    // Roll low event below a positive threshold, released at once.
    setup(32'h04, 32'h00);
    smp(16'h0064 - 16'($urandom_range(300, 1)), 16'h0, 1'h1);
    smp(16'h0064, 16'h0, 1'h0);
    // Latched request survives a quiet sample until the source register is read.
    setup(32'h48, 32'h00);
    smp(above(), 16'h0, 1'h1);
    smp(16'h0, 16'h0, 1'h1);
    rd(`GTE_IDX_SOURCE, 32'h3);
    smp(16'h0, 16'h0, 1'h0);
    repeat (4) @(posedge mclk);
    end_of_test();
  end

endmodule
